// ---- rtl/trx_pkg.sv ----
// Package with register map, field layout, timing and types of the transceiver register bank.
package trx_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_PERIOD_NS = 1000;
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);

  localparam logic [2:0] DEV_ADDR = 3'h5;
  localparam logic [4:0] HDR_BITS = 5'h09;
  localparam logic [4:0] FRAME_BITS = 5'h19;

  localparam logic [4:0] REG_DC_EST = 5'h00;
  localparam logic [4:0] REG_LOCK = 5'h05;
  localparam logic [4:0] REG_SYNTH_PROG = 5'h07;
  localparam logic [4:0] REG_AUX_PLL = 5'h08;
  localparam logic [4:0] REG_POWER_CLOCK = 5'h09;
  localparam logic [4:0] REG_RSVD_A = 5'h0A;
  localparam logic [4:0] REG_OSC_EN = 5'h0B;
  localparam logic [4:0] REG_XTAL = 5'h0C;
  localparam logic [4:0] REG_RSVD_D = 5'h0D;
  localparam logic [4:0] REG_MOD_OFF = 5'h0E;
  localparam logic [4:0] REG_RSVD_F = 5'h0F;
  localparam logic [4:0] REG_RSVD_10 = 5'h10;
  localparam logic [4:0] REG_RSVD_11 = 5'h11;
  localparam logic [4:0] REG_SEQ_DC = 5'h12;
  localparam logic [4:0] REG_RSVD_14 = 5'h14;
  localparam logic [4:0] REG_FREQ = 5'h15;
  localparam logic [4:0] REG_AMP = 5'h16;
  localparam logic [4:0] REG_SWITCH = 5'h17;
  localparam logic [4:0] REG_CODE_LO = 5'h1E;
  localparam logic [4:0] REG_CODE_HI = 5'h1F;

  localparam int unsigned PWR_LVL_LSB = 7;
  localparam int unsigned AUX_PLL_POWERDOWN_BIT = 2;
  localparam int unsigned CLK_SEL_BIT = 1;
  localparam int unsigned XO_EN_BIT = 0;
  localparam int unsigned TUNE_LSB = 13;
  localparam int unsigned LOAD_LSB = 8;
  localparam int unsigned BIAS_BIT = 7;
  localparam int unsigned DLY_HI_LSB = 8;
  localparam int unsigned DLY_LO_LSB = 0;
  localparam int unsigned SEQ_SEL_BIT = 15;
  localparam int unsigned DC_MODE_LSB = 13;
  localparam int unsigned POST_DC_LSB = 12;
  localparam int unsigned VCO_BIT = 14;
  localparam int unsigned SYN_BIT = 13;
  localparam int unsigned DIRECT_BIT = 12;
  localparam int unsigned SWALLOW_LSB = 9;
  localparam int unsigned LOCK_BIT = 8;

  typedef struct packed {
    logic modulator_on;
    logic amp_on;
    logic tr_switch_tx;
  } trx_seq_t;

  typedef struct packed {
    logic hold_fixed;
    logic fixed_before_preamble;
    logic [6:0] est_symbols;
  } trx_dc_t;

  function automatic logic [15:0] reg_reset(input logic [4:0] idx);
    case (idx)
      REG_DC_EST: reg_reset = 16'h1000;
      REG_LOCK: reg_reset = 16'h4D0C;
      REG_SYNTH_PROG: reg_reset = 16'h0030;
      REG_AUX_PLL: reg_reset = 16'h1676;
      REG_POWER_CLOCK: reg_reset = 16'h6803;
      REG_RSVD_A: reg_reset = 16'h0004;
      REG_OSC_EN: reg_reset = 16'h4040;
      REG_XTAL: reg_reset = 16'h9000;
      REG_MOD_OFF: reg_reset = 16'h0200;
      REG_RSVD_F: reg_reset = 16'h7193;
      REG_RSVD_10: reg_reset = 16'hC9CF;
      REG_RSVD_11: reg_reset = 16'hD3D7;
      REG_RSVD_14: reg_reset = 16'h83E0;
      REG_FREQ: reg_reset = 16'h0962;
      REG_AMP: reg_reset = 16'h0A02;
      REG_SWITCH: reg_reset = 16'h0302;
      default: reg_reset = 16'h0000;
    endcase
  endfunction : reg_reset

  function automatic logic reg_mapped(input logic [4:0] idx);
    case (idx)
      REG_DC_EST, REG_LOCK, REG_SYNTH_PROG, REG_AUX_PLL, REG_POWER_CLOCK, REG_RSVD_A,
      REG_OSC_EN, REG_XTAL, REG_RSVD_D, REG_MOD_OFF, REG_RSVD_F, REG_RSVD_10,
      REG_RSVD_11, REG_SEQ_DC, REG_RSVD_14, REG_FREQ, REG_AMP, REG_SWITCH:
        reg_mapped = 1'b1;
      default: reg_mapped = 1'b0;
    endcase
  endfunction : reg_mapped

endpackage : trx_pkg

// ---- rtl/trx_regs.sv ----
// Register bank with three-wire serial slave and transmit sequencing counters.
`timescale 1ns/1ps

// Contract
// - Power code maps to amplifier output level
// - Power-down bit switches auxiliary PLL off
// - Clock pin shows PLL clock or symbol clock
// - Oscillator enable bit starts crystal oscillator
// - Fine-tune field trims crystal, reset 100
// - Nonzero load selects load; bias bit
// - Modulator-off delay counts after amplifier off
// - Select bit picks hardware or software sequencing
// - DC offset mode codes after strobe
// - Modulator-on delay counted from strobe
// - VCO powers down in idle if set
// - Synthesizer powers down in idle if set
// - Direct bit picks divider or channel frequency
// - Base frequency used only in channel mode
// - Amplifier-on delay from modulator or strobe
// - Amplifier-off delay switches amplifier off
// - Switch delay from amplifier or strobe
// - Maker code read-only at 30, 31
// - Post-strobe window: fixed, 16, 32, 64
// - Lock bit restricts writes to 7,8,9 and the lock bit itself
// - Frame: address 101, rw, register, data
module trx_regs #(
  parameter logic [15:0] MAKER_CODE_LOW = 16'h1234,
  parameter logic [15:0] MAKER_CODE_HIGH = 16'h5678
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic bus_enable_n,
  input wire logic bus_clock,
  input wire logic bus_data_in,
  output logic bus_data_out,
  output logic bus_data_oe,
  input wire logic packet_control_strobe,
  input wire logic amp_off_request,
  input wire logic in_idle,
  input wire logic aux_pll_clock,
  input wire logic tx_symbol_clock,
  output logic clock_out_pin,
  output logic [2:0] tx_power_level,
  output logic [6:0] tx_power_dbm,
  output logic aux_pll_powerdown,
  output logic crystal_osc_enable,
  output logic [2:0] crystal_fine_tune,
  output logic [2:0] crystal_load,
  output logic crystal_load_enable,
  output logic crystal_bias_enable,
  output logic vco_power_on,
  output logic synth_power_on,
  output logic direct_freq_program,
  output logic [11:0] synth_divider_word,
  output trx_pkg::trx_dc_t dc_setting,
  output trx_pkg::trx_seq_t tx_seq
);
  import trx_pkg::*;

  typedef enum logic [1:0] {OFF_IDLE, OFF_AMP, OFF_MOD} trx_off_t;

  logic en_s1_ff, en_s2_ff;
  logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic din_s1_ff, din_s2_ff;
  logic stb_s1_ff, stb_s2_ff, stb_s3_ff;
  logic aux_pll_s1_ff, aux_pll_s2_ff;
  logic txck_s1_ff, txck_s2_ff;
  logic [15:0] regs_ff [0:31];
  logic [4:0] bit_cnt_ff;
  logic [23:0] shift_ff;
  logic rd_mode_ff;
  logic [15:0] rd_shift_ff, rd_word;
  logic [5:0] tick_cnt_ff;
  logic tick_ff;
  logic mod_run_ff, amp_run_ff, sw_run_ff;
  logic [7:0] mod_cnt_ff, amp_cnt_ff, sw_cnt_ff, off_cnt_ff;
  trx_off_t off_state_ff;
  logic frame_active, sclk_rise, sclk_fall, strobe_rise;
  logic [24:0] word_in;
  logic commit;
  logic sw_mode;
  logic mod_fire, amp_fire, sw_fire, amp_off_fire, mod_off_fire;

  function automatic logic [6:0] power_dbm(input logic [2:0] code);
    case (code)
      3'h0: power_dbm = 7'h02;
      3'h1: power_dbm = 7'h7C;
      3'h2: power_dbm = 7'h76;
      3'h3: power_dbm = 7'h73;
      3'h4: power_dbm = 7'h6E;
      3'h5: power_dbm = 7'h69;
      default: power_dbm = 7'h60;
    endcase
  endfunction : power_dbm

  function automatic logic [6:0] window_symbols(input logic [1:0] code);
    case (code)
      2'h1: window_symbols = 7'h10;
      2'h2: window_symbols = 7'h20;
      2'h3: window_symbols = 7'h40;
      default: window_symbols = 7'h00;
    endcase
  endfunction : window_symbols

  function automatic logic [15:0] read_value(input logic [4:0] idx, input logic [15:0] val);
    if (idx == REG_CODE_LO) begin
      read_value = MAKER_CODE_LOW;
    end else if (idx == REG_CODE_HI) begin
      read_value = MAKER_CODE_HIGH;
    end else if (reg_mapped(idx)) begin
      read_value = val;
    end else begin
      read_value = 16'h0000;
    end
  endfunction : read_value

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      en_s1_ff <= 1'b1;
      en_s2_ff <= 1'b1;
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
      stb_s1_ff <= 1'b0;
      stb_s2_ff <= 1'b0;
      stb_s3_ff <= 1'b0;
      aux_pll_s1_ff <= 1'b0;
      aux_pll_s2_ff <= 1'b0;
      txck_s1_ff <= 1'b0;
      txck_s2_ff <= 1'b0;
    end else begin
      en_s1_ff <= bus_enable_n;
      en_s2_ff <= en_s1_ff;
      sclk_s1_ff <= bus_clock;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      din_s1_ff <= bus_data_in;
      din_s2_ff <= din_s1_ff;
      stb_s1_ff <= packet_control_strobe;
      stb_s2_ff <= stb_s1_ff;
      stb_s3_ff <= stb_s2_ff;
      aux_pll_s1_ff <= aux_pll_clock;
      aux_pll_s2_ff <= aux_pll_s1_ff;
      txck_s1_ff <= tx_symbol_clock;
      txck_s2_ff <= txck_s1_ff;
    end
  end

  assign frame_active = ~en_s2_ff;
  assign sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
  assign sclk_fall = ~sclk_s2_ff & sclk_s3_ff;
  assign strobe_rise = stb_s2_ff & ~stb_s3_ff;
  assign word_in = {shift_ff, din_s2_ff};
  assign rd_word = read_value(shift_ff[4:0], regs_ff[shift_ff[4:0]]);
  // Write taken on the last data bit when the device address matches.
  assign commit = frame_active & sclk_rise & (bit_cnt_ff == FRAME_BITS - 5'h01)
                  & (word_in[24:22] == DEV_ADDR) & ~word_in[21];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bit_cnt_ff <= 5'h00;
      shift_ff <= 24'h000000;
    end else if (!frame_active) begin
      bit_cnt_ff <= 5'h00;
    end else if (sclk_rise && bit_cnt_ff < FRAME_BITS) begin
      shift_ff <= word_in[23:0];
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end
  end

  // Read data shifted out on falling clock edges, MSB first.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_mode_ff <= 1'b0;
      rd_shift_ff <= 16'h0000;
      bus_data_out <= 1'b0;
      bus_data_oe <= 1'b0;
    end else if (!frame_active) begin
      rd_mode_ff <= 1'b0;
      bus_data_oe <= 1'b0;
    end else if (sclk_fall && bit_cnt_ff == HDR_BITS) begin
      if (shift_ff[8:6] == DEV_ADDR && shift_ff[5]) begin
        // Maker code halves answer at the top two addresses.
        rd_shift_ff <= {rd_word[14:0], 1'b0};
        bus_data_out <= rd_word[15];
        bus_data_oe <= 1'b1;
        rd_mode_ff <= 1'b1;
      end
    end else if (sclk_fall && rd_mode_ff && bit_cnt_ff < FRAME_BITS) begin
      bus_data_out <= rd_shift_ff[15];
      rd_shift_ff <= {rd_shift_ff[14:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) begin
        regs_ff[i] <= reg_reset(5'(i));
      end
    end else if (commit) begin
      // Write lock admits only the open registers and the lock bit.
      if (regs_ff[REG_LOCK][LOCK_BIT]) begin
        if (word_in[20:16] == REG_SYNTH_PROG || word_in[20:16] == REG_AUX_PLL ||
            word_in[20:16] == REG_POWER_CLOCK) begin
          regs_ff[word_in[20:16]] <= word_in[15:0];
        end else if (word_in[20:16] == REG_LOCK) begin
          regs_ff[REG_LOCK][LOCK_BIT] <= word_in[LOCK_BIT];
        end
      end else if (reg_mapped(word_in[20:16])) begin
        regs_ff[word_in[20:16]] <= word_in[15:0];
      end
    end
  end

  // One-microsecond tick from the core clock.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick_cnt_ff <= 6'h00;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == TICK_LAST) begin
      tick_cnt_ff <= 6'h00;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 6'h01;
      tick_ff <= 1'b0;
    end
  end

  assign sw_mode = regs_ff[REG_SEQ_DC][SEQ_SEL_BIT];
  // A counter at zero fires on the next tick.
  assign mod_fire = tick_ff & mod_run_ff & (mod_cnt_ff == 8'h00);
  assign amp_fire = tick_ff & amp_run_ff & (amp_cnt_ff == 8'h00);
  assign sw_fire = tick_ff & sw_run_ff & (sw_cnt_ff == 8'h00);
  assign amp_off_fire = tick_ff & (off_state_ff == OFF_AMP) & (off_cnt_ff == 8'h00);
  assign mod_off_fire = tick_ff & (off_state_ff == OFF_MOD) & (off_cnt_ff == 8'h00);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mod_run_ff <= 1'b0;
      amp_run_ff <= 1'b0;
      sw_run_ff <= 1'b0;
      mod_cnt_ff <= 8'h00;
      amp_cnt_ff <= 8'h00;
      sw_cnt_ff <= 8'h00;
    end else if (strobe_rise) begin
      // Modulator delay starts at the strobe edge in both modes.
      mod_run_ff <= 1'b1;
      mod_cnt_ff <= regs_ff[REG_SEQ_DC][DLY_LO_LSB +: 8];
      // Software mode starts all three delays from the strobe.
      amp_run_ff <= sw_mode;
      amp_cnt_ff <= regs_ff[REG_AMP][DLY_HI_LSB +: 8];
      sw_run_ff <= sw_mode;
      sw_cnt_ff <= regs_ff[REG_SWITCH][DLY_HI_LSB +: 8];
    end else if (tick_ff) begin
      if (mod_run_ff) begin
        mod_run_ff <= (mod_cnt_ff != 8'h00);
        mod_cnt_ff <= mod_cnt_ff - 8'h01;
      end
      // Hardware mode chains amplifier delay from modulator on.
      if (mod_fire && !sw_mode) begin
        amp_run_ff <= 1'b1;
        amp_cnt_ff <= regs_ff[REG_AMP][DLY_HI_LSB +: 8];
      end else if (amp_run_ff) begin
        amp_run_ff <= (amp_cnt_ff != 8'h00);
        amp_cnt_ff <= amp_cnt_ff - 8'h01;
      end
      // Hardware mode chains switch delay from amplifier on.
      if (amp_fire && !sw_mode) begin
        sw_run_ff <= 1'b1;
        sw_cnt_ff <= regs_ff[REG_SWITCH][DLY_HI_LSB +: 8];
      end else if (sw_run_ff) begin
        sw_run_ff <= (sw_cnt_ff != 8'h00);
        sw_cnt_ff <= sw_cnt_ff - 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      off_state_ff <= OFF_IDLE;
      off_cnt_ff <= 8'h00;
    end else if (strobe_rise) begin
      off_state_ff <= OFF_IDLE;
    end else if (amp_off_request && off_state_ff == OFF_IDLE) begin
      // Amplifier-off delay loaded on entering the off state.
      off_state_ff <= OFF_AMP;
      off_cnt_ff <= regs_ff[REG_AMP][DLY_LO_LSB +: 8];
    end else if (tick_ff) begin
      case (off_state_ff)
        OFF_AMP: begin
          if (off_cnt_ff == 8'h00) begin
            // Modulator-off delay loaded once the amplifier is off.
            off_state_ff <= OFF_MOD;
            off_cnt_ff <= regs_ff[REG_MOD_OFF][DLY_HI_LSB +: 8];
          end else begin
            off_cnt_ff <= off_cnt_ff - 8'h01;
          end
        end
        OFF_MOD: begin
          if (off_cnt_ff == 8'h00) begin
            off_state_ff <= OFF_IDLE;
          end else begin
            off_cnt_ff <= off_cnt_ff - 8'h01;
          end
        end
        default: off_state_ff <= OFF_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_seq <= '0;
    end else begin
      // Modulator on at end of its delay, off after off delay.
      if (mod_fire) begin
        tx_seq.modulator_on <= 1'b1;
      end else if (mod_off_fire) begin
        tx_seq.modulator_on <= 1'b0;
      end
      // Amplifier and switch drop when the off delay ends.
      if (amp_fire) begin
        tx_seq.amp_on <= 1'b1;
      end else if (amp_off_fire) begin
        tx_seq.amp_on <= 1'b0;
      end
      if (sw_fire) begin
        tx_seq.tr_switch_tx <= 1'b1;
      end else if (amp_off_fire) begin
        tx_seq.tr_switch_tx <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clock_out_pin <= 1'b0;
      tx_power_level <= 3'h0;
      tx_power_dbm <= 7'h00;
      aux_pll_powerdown <= 1'b0;
      crystal_osc_enable <= 1'b0;
      crystal_fine_tune <= 3'h0;
      crystal_load <= 3'h0;
      crystal_load_enable <= 1'b0;
      crystal_bias_enable <= 1'b0;
      vco_power_on <= 1'b0;
      synth_power_on <= 1'b0;
      direct_freq_program <= 1'b0;
      synth_divider_word <= 12'h000;
      dc_setting <= '0;
    end else begin
      // Clock pin source follows the select bit.
      clock_out_pin <= regs_ff[REG_POWER_CLOCK][CLK_SEL_BIT] ? aux_pll_s2_ff : txck_s2_ff;
      // Power code and its typical level in dBm.
      tx_power_level <= regs_ff[REG_POWER_CLOCK][PWR_LVL_LSB +: 3];
      tx_power_dbm <= power_dbm(regs_ff[REG_POWER_CLOCK][PWR_LVL_LSB +: 3]);
      aux_pll_powerdown <= regs_ff[REG_POWER_CLOCK][AUX_PLL_POWERDOWN_BIT];
      crystal_osc_enable <= regs_ff[REG_OSC_EN][XO_EN_BIT];
      crystal_fine_tune <= regs_ff[REG_XTAL][TUNE_LSB +: 3];
      // Load selected when nonzero; bias point switch.
      crystal_load <= regs_ff[REG_XTAL][LOAD_LSB +: 3];
      crystal_load_enable <= (regs_ff[REG_XTAL][LOAD_LSB +: 3] != 3'h0);
      crystal_bias_enable <= regs_ff[REG_XTAL][BIAS_BIT];
      // VCO off only in idle with shutdown set.
      vco_power_on <= ~(in_idle & regs_ff[REG_FREQ][VCO_BIT]);
      // Synthesizer off only in idle with shutdown set.
      synth_power_on <= ~(in_idle & regs_ff[REG_FREQ][SYN_BIT]);
      direct_freq_program <= regs_ff[REG_FREQ][DIRECT_BIT];
      // Direct divider fields or base plus channel.
      // Base frequency ignored in direct mode.
      if (regs_ff[REG_FREQ][DIRECT_BIT]) begin
        synth_divider_word <= {regs_ff[REG_SYNTH_PROG][SWALLOW_LSB +: 5],
                               regs_ff[REG_SYNTH_PROG][6:0]};
      end else begin
        synth_divider_word <= 12'(regs_ff[REG_FREQ][11:0]
                                  + {5'h00, regs_ff[REG_SYNTH_PROG][6:0]});
      end
      // Mode 00 fixed before preamble, 01 eight symbols, 1x window.
      // Window code 00 holds offset, else 16, 32 or 64 symbols.
      case (regs_ff[REG_SEQ_DC][DC_MODE_LSB +: 2])
        2'h0: dc_setting <= '{hold_fixed: 1'b1, fixed_before_preamble: 1'b1,
                              est_symbols: 7'h00};
        2'h1: dc_setting <= '{hold_fixed: 1'b0, fixed_before_preamble: 1'b0,
                              est_symbols: 7'h08};
        default: dc_setting <= '{
          hold_fixed: (regs_ff[REG_DC_EST][POST_DC_LSB +: 2] == 2'h0),
          fixed_before_preamble: 1'b0,
          est_symbols: window_symbols(regs_ff[REG_DC_EST][POST_DC_LSB +: 2])};
      endcase
    end
  end

endmodule : trx_regs

// ---- bench/trx_regs_asserts.sv ----
// Checker of the register bank output relations.
`timescale 1ns/1ps
module trx_regs_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic bus_enable_n,
  input wire logic bus_data_oe,
  input wire logic in_idle,
  input wire logic [2:0] tx_power_level,
  input wire logic [6:0] tx_power_dbm,
  input wire logic [2:0] crystal_load,
  input wire logic crystal_load_enable,
  input wire logic vco_power_on,
  input wire logic synth_power_on,
  input wire trx_pkg::trx_dc_t dc_setting,
  input wire trx_pkg::trx_seq_t tx_seq
);
  import trx_pkg::*;
  logic [6:0] exp_dbm;
  always_comb begin
    case (tx_power_level)
      3'h0: exp_dbm = 7'h02;
      3'h1: exp_dbm = 7'h7C;
      3'h2: exp_dbm = 7'h76;
      3'h3: exp_dbm = 7'h73;
      3'h4: exp_dbm = 7'h6E;
      3'h5: exp_dbm = 7'h69;
      default: exp_dbm = 7'h60;
    endcase
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_PWR_MAP: assert property (!$past(reset) |-> tx_power_dbm == exp_dbm)
    else $error("power level mapping wrong");
  AST_LOAD_EN: assert property (crystal_load_enable == (crystal_load != 3'h0))
    else $error("crystal load enable wrong");
  AST_VCO_BUSY: assert property (!$past(reset) && !$past(in_idle) |-> vco_power_on)
    else $error("vco off outside idle");
  AST_SYN_BUSY: assert property (!$past(reset) && !$past(in_idle) |-> synth_power_on)
    else $error("synthesizer off outside idle");
  AST_OE_QUIET: assert property (bus_enable_n [*5] |-> !bus_data_oe)
    else $error("data driven with bus disabled");
  AST_OE_START: assert property ($rose(bus_data_oe) |-> !bus_enable_n)
    else $error("data drive started outside frame");
  AST_AMP_OFF: assert property ($fell(tx_seq.amp_on) |-> !tx_seq.tr_switch_tx)
    else $error("switch still on after amplifier off");
  AST_MOD_LAST: assert property ($fell(tx_seq.modulator_on) |-> !tx_seq.amp_on)
    else $error("modulator off before amplifier");
  AST_DC_HOLD: assert property (!$past(reset) |->
      dc_setting.hold_fixed == (dc_setting.est_symbols == 7'h00))
    else $error("dc hold and window disagree");
  AST_DC_SET: assert property (!$past(reset) |->
      dc_setting.est_symbols inside {7'h00, 7'h08, 7'h10, 7'h20, 7'h40})
    else $error("dc window not a legal length");
endmodule : trx_regs_asserts
bind trx_regs trx_regs_asserts u_chk (.core_clk(core_clk), .reset(reset),
  .bus_enable_n(bus_enable_n), .bus_data_oe(bus_data_oe), .in_idle(in_idle),
  .tx_power_level(tx_power_level), .tx_power_dbm(tx_power_dbm), .crystal_load(crystal_load),
  .crystal_load_enable(crystal_load_enable), .vco_power_on(vco_power_on),
  .synth_power_on(synth_power_on), .dc_setting(dc_setting), .tx_seq(tx_seq));

// ---- bench/trx_host_model.sv ----
// Baseband controller model driving the three-wire serial bus.
`timescale 1ns/1ps
module trx_host_model (
  input wire logic core_clk,
  output logic bus_enable_n,
  output logic bus_clock,
  output logic bus_data_in,
  input wire logic bus_data_out,
  input wire logic bus_data_oe
);
  logic host_drv = 1'b0;
  assign bus_data_in = bus_data_oe ? bus_data_out : host_drv;
  initial begin
    bus_enable_n = 1'b1;
    bus_clock = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic frame(input logic [2:0] dev, input logic rw, input logic [4:0] addr,
      input logic [15:0] wdata, output logic [15:0] rdata);
    logic [24:0] bits;
    bits = {dev, rw, addr, wdata};
    rdata = 16'h0000;
    bus_enable_n = 1'b0;
    step(4);
    for (int i = 24; i >= 0; i--) begin
      // A released line shows a changing pattern, not the last bit.
      host_drv = (rw && i < 16) ? ~host_drv : bits[i];
      step(4);
      bus_clock = 1'b1;
      rdata = {rdata[14:0], bus_data_in};
      step(4);
      bus_clock = 1'b0;
    end
    step(4);
    bus_enable_n = 1'b1;
    step(6);
  endtask : frame
endmodule : trx_host_model

// ---- bench/transceiver_tx_sequencing_regs_bench.sv ----
// Self-checking bench for the transceiver register bank.
`timescale 1ns/1ps
module transceiver_tx_sequencing_regs_bench;
  import trx_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic strobe = 1'b0, off_req = 1'b0, in_idle = 1'b0, aux_pll = 1'b1, symclk = 1'b0;
  wire logic en_n, bclk, bdin, bdout, boe;
  logic clk_pin, pd, xo, ld_en, bias, vco, syn, dir;
  logic [2:0] lvl, tune, load;
  logic [6:0] dbm;
  logic [11:0] word;
  trx_dc_t dc;
  trx_seq_t seq;
  int failures = 0;
  int check_count = 0;
  always #10 core_clk = ~core_clk;
  // Maker code values are arbitrary.
  trx_regs #(.MAKER_CODE_LOW(16'hA5C3), .MAKER_CODE_HIGH(16'h3C5A)) dut (
    .core_clk(core_clk), .reset(reset), .bus_enable_n(en_n), .bus_clock(bclk),
    .bus_data_in(bdin), .bus_data_out(bdout), .bus_data_oe(boe),
    .packet_control_strobe(strobe), .amp_off_request(off_req), .in_idle(in_idle),
    .aux_pll_clock(aux_pll), .tx_symbol_clock(symclk), .clock_out_pin(clk_pin),
    .tx_power_level(lvl), .tx_power_dbm(dbm), .aux_pll_powerdown(pd),
    .crystal_osc_enable(xo), .crystal_fine_tune(tune), .crystal_load(load),
    .crystal_load_enable(ld_en), .crystal_bias_enable(bias), .vco_power_on(vco),
    .synth_power_on(syn), .direct_freq_program(dir), .synth_divider_word(word),
    .dc_setting(dc), .tx_seq(seq));
  trx_host_model host (.core_clk(core_clk), .bus_enable_n(en_n), .bus_clock(bclk),
    .bus_data_in(bdin), .bus_data_out(bdout), .bus_data_oe(boe));
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_n(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      failures++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_n
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    host.frame(DEV_ADDR, 1'b0, a, d, q);
  endtask : wr
  task automatic rdc(input string nm, input logic [4:0] a, input logic [15:0] e);
    logic [15:0] q;
    host.frame(DEV_ADDR, 1'b1, a, 16'h0000, q);
    chk(nm, e, q);
  endtask : rdc
  task automatic wait_seq(input trx_seq_t t, output int n);
    n = 0;
    while (seq !== t && n < 20000) begin
      step(1);
      n++;
    end
    if (n >= 20000) begin
      failures++;
      conclude();
    end
  endtask : wait_seq
  task automatic t_reset;
    rdc("osc", REG_OSC_EN, 16'h4040);
    rdc("xtal", REG_XTAL, 16'h9000);
    rdc("modoff", REG_MOD_OFF, 16'h0200);
    rdc("seqdc", REG_SEQ_DC, 16'h0000);
    rdc("freq", REG_FREQ, 16'h0962);
    rdc("amp", REG_AMP, 16'h0A02);
    rdc("sw", REG_SWITCH, 16'h0302);
    rdc("codelo", REG_CODE_LO, 16'hA5C3);
    rdc("codehi", REG_CODE_HI, 16'h3C5A);
    rdc("unmapped", 5'h13, 16'h0000);
    chk("tune", 16'(tune), 16'h0004);
    chk("word", 16'(word), 16'h0992);
    chk("clksel", 16'(clk_pin), 16'h0001);
    $display("test reset done");
  endtask : t_reset
  task automatic t_lock;
    logic [15:0] q;
    wr(REG_XTAL, 16'h0000);
    rdc("locked", REG_XTAL, 16'h9000);
    wr(REG_CODE_LO, 16'h0000);
    rdc("ro", REG_CODE_LO, 16'hA5C3);
    host.frame(3'h4, 1'b0, REG_LOCK, 16'h0000, q);
    rdc("devaddr", REG_LOCK, 16'h4D0C);
    wr(REG_LOCK, 16'h0000);
    rdc("unlock", REG_LOCK, 16'h4C0C);
    wr(REG_XTAL, 16'hA380);
    rdc("unlocked", REG_XTAL, 16'hA380);
    chk("xtalout", 16'({tune, load, ld_en, bias}), 16'h00AF);
    wr(REG_XTAL, 16'h0000);
    chk("noload", 16'({load, ld_en, bias}), 16'h0000);
    wr(REG_OSC_EN, 16'h0001);
    chk("xo", 16'(xo), 16'h0001);
    $display("test lock done");
  endtask : t_lock
  task automatic t_power;
    logic [6:0] tab [8] = '{7'h02, 7'h7C, 7'h76, 7'h73, 7'h6E, 7'h69, 7'h60, 7'h60};
    for (int c = 0; c < 8; c++) begin
      wr(REG_POWER_CLOCK, 16'h6801 | (16'(c) << 7) | (16'(c[1]) << 2) | (16'(c[0]) << 1));
      chk("dbm", 16'(dbm), 16'(tab[c]));
      chk("pll", 16'({pd, clk_pin, lvl}), 16'({c[1], c[0], c[2:0]}));
    end
    $display("test power done");
  endtask : t_power
  task automatic t_freq;
    wr(REG_SYNTH_PROG, 16'h1405);
    wr(REG_FREQ, 16'h6100);
    chk("chan", 16'({dir, word}), 16'h0105);
    in_idle = 1'b1;
    step(3);
    chk("idleoff", 16'({vco, syn}), 16'h0000);
    wr(REG_FREQ, 16'h1100);
    chk("direct", 16'({dir, word}), 16'h1505);
    chk("idleon", 16'({vco, syn}), 16'h0003);
    in_idle = 1'b0;
    $display("test freq done");
  endtask : t_freq
  task automatic t_dc;
    logic [8:0] e [4] = '{9'h100, 9'h010, 9'h020, 9'h040};
    wr(REG_SEQ_DC, 16'h0000);
    chk("dc00", 16'(dc), 16'h0180);
    wr(REG_SEQ_DC, 16'h2000);
    chk("dc01", 16'(dc), 16'h0008);
    for (int w = 0; w < 4; w++) begin
      wr(REG_DC_EST, 16'(w) << 12);
      wr(REG_SEQ_DC, w[0] ? 16'h6000 : 16'h4000);
      chk("dcwin", 16'(dc), 16'(e[w]));
    end
    $display("test dc done");
  endtask : t_dc
  task automatic t_seq_hw;
    int n;
    wr(REG_SEQ_DC, 16'h0002);
    wr(REG_AMP, 16'h0103);
    wr(REG_SWITCH, 16'h0000);
    wr(REG_MOD_OFF, 16'h0100);
    strobe = 1'b1;
    wait_seq(3'b100, n);
    chk_n("modon", 100, 156, n);
    wait_seq(3'b110, n);
    chk_n("ampon", 100, 100, n);
    wait_seq(3'b111, n);
    chk_n("swon", 50, 50, n);
    strobe = 1'b0;
    off_req = 1'b1;
    step(1);
    off_req = 1'b0;
    wait_seq(3'b100, n);
    chk_n("ampoff", 145, 205, n);
    wait_seq(3'b000, n);
    chk_n("modoff", 100, 100, n);
    $display("test hardware sequence done");
  endtask : t_seq_hw
  task automatic t_seq_sw;
    int n;
    wr(REG_SEQ_DC, 16'h8003);
    wr(REG_SWITCH, 16'h0500);
    strobe = 1'b1;
    wait_seq(3'b010, n);
    chk_n("swamp", 50, 106, n);
    wait_seq(3'b110, n);
    chk_n("swmod", 100, 100, n);
    wait_seq(3'b111, n);
    chk_n("swsw", 100, 100, n);
    strobe = 1'b0;
    $display("test software sequence done");
  endtask : t_seq_sw
  initial begin
    step(5);
    reset = 1'b0;
    step(3);
    t_reset();
    t_lock();
    t_power();
    t_freq();
    t_dc();
    t_seq_hw();
    t_seq_sw();
    conclude();
  end
endmodule : transceiver_tx_sequencing_regs_bench
